// ==== rtl/mcver_pkg.sv ====
// Behaviour
// - opcode 37 stores value field as handler address for interrupt number in type
// - redefining a vector for the same interrupt overwrites the old address
// - enable-interrupt with number 255 turns on interrupt processing globally
// - opcode 38 ends the handler and resumes interrupted program flow
// - return restores saved accumulator, X register, flags and program counter
// - opcodes 64..71 are user functions replying status 100, user value
// - opcode 138 gives immediate reply and later extra reply on target reached
// - position-reached request is accepted only as a direct host command
// - request value is a motor bit mask, bit n selects motor n
// - type 0 arms a message only for the next move-to-position command
// - type 1 arms a message for every following move-to-position command
// - immediate reply: status 64h, command 8Ah, mask in low byte, upper bytes zero
// - extra reply: status 80h, command 8Ah, mask in low value byte
package mcver_pkg;
  localparam logic [7:0] OP_MVP_C    = 8'h04;
  localparam logic [7:0] OP_EIRQ_C   = 8'h19;
  localparam logic [7:0] OP_DEFINE_IRQ_VECTOR_C   = 8'h25;
  localparam logic [7:0] OP_RETURN_FROM_IRQ_C   = 8'h26;
  localparam logic [7:0] OP_UF_LO_C  = 8'h40;
  localparam logic [7:0] OP_UF_HI_C  = 8'h47;
  localparam logic [7:0] OP_PREQ_C   = 8'h8a;
  localparam logic [7:0] ST_OK_C     = 8'h64;
  localparam logic [7:0] ST_EVT_C    = 8'h80;
  localparam logic [7:0] ST_CHK_C    = 8'h01;
  localparam logic [7:0] ST_BADCMD_C = 8'h02;
  localparam logic [7:0] IRQ_ALL_C   = 8'hff;
  localparam int         FRAME_LEN_C = 9;
  localparam logic [7:0] MOD_ADDR_C  = 8'h01;
  localparam logic [7:0] HOST_ADDR_C = 8'h02;
  // register byte offsets on the lite bus
  localparam logic [7:0] RA_CTRL_C   = 8'h00;
  localparam logic [7:0] RA_STAT_C   = 8'h04;
  localparam logic [7:0] RA_MASK_C   = 8'h08;
  localparam logic [7:0] RA_ACC_C    = 8'h0c;
  localparam logic [7:0] RA_X_C      = 8'h10;
  localparam logic [7:0] RA_PC_C     = 8'h14;
  localparam logic [7:0] RA_FLAG_C   = 8'h18;
  localparam logic [7:0] RA_UFV_C    = 8'h1c;
  localparam logic [1:0] RESP_OK_C   = 2'b00;
  localparam logic [1:0] RESP_ERR_C  = 2'b10;
  localparam int         NUM_IRQ_C   = 16;
endpackage

// ==== rtl/mcver_mem_if.sv ====
`timescale 1ns/1ps
interface mcver_mem_if #(parameter int AW = 4, parameter int DW = 24);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== rtl/mcver_vecmem.sv ====
`timescale 1ns/1ps
module mcver_vecmem #(
  parameter int DEPTH = 16
) (
  input  wire logic clk_i,
  input  wire logic ce_i,
  mcver_mem_if.mem  bus
);
  logic [23:0] mem [DEPTH];
  logic [23:0] rd;
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (bus.we) begin
        mem[bus.waddr] <= bus.wdata;
      end
      rd <= mem[bus.raddr];
    end
  end
  assign bus.rdata = rd;
endmodule

// ==== rtl/mcver_csum.sv ====
`timescale 1ns/1ps
module mcver_csum (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       clr_i,
  input  wire logic       add_i,
  input  wire logic [7:0] byte_i,
  output logic      [7:0] sum_o
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sum_o <= 8'h00;
    end else if (ce_i) begin
      if (clr_i) begin
        sum_o <= 8'h00;
      end else if (add_i) begin
        sum_o <= sum_o + byte_i;
      end
    end
  end
endmodule

// ==== rtl/mcver_top.sv ====
`timescale 1ns/1ps
module mcver_top #(
  parameter int NUM_MOTORS = 3
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,
  input  wire logic        RX_VALID_I,
  input  wire logic [7:0]  RX_BYTE_I,
  output logic             TX_VALID_O,
  output logic      [7:0]  TX_BYTE_O,
  input  wire logic        TX_READY_I,
  input  wire logic [NUM_MOTORS-1:0] REACHED_I,
  output logic             IRQ_GLOBAL_O,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  typedef enum {S_RX, S_EXEC, S_WAITV, S_TX} mcver_st_t;
  typedef struct packed {
    mcver_st_t   st;
    logic [3:0]  rx_cnt;
    logic [63:0] rx_buf;
    logic [3:0]  tx_cnt;
    logic [63:0] tx_buf;
    logic        tx_valid;
    logic [7:0]  tx_byte;
    logic        evt_pend;
    logic        arm_once;
    logic        arm_all;
    logic [7:0]  mask;
    logic [7:0]  watch;
    logic        irq_glob;
    logic        in_irq;
    logic        prog_mode;
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [3:0]  flags;
    logic [23:0] pc;
    logic [31:0] sv_acc;
    logic [31:0] sv_x;
    logic [3:0]  sv_flags;
    logic [23:0] sv_pc;
    logic [31:0] uf_val;
    logic        irq_take;
    logic [3:0]  irq_num;
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  aw_a;
    logic [31:0] w_d;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } mcver_state_t;

  mcver_state_t s, next_s;
  logic [7:0] csum;
  logic       cs_clr, cs_add;
  mcver_mem_if #(.AW(4), .DW(24)) vif ();

  mcver_csum u_csum (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .ce_i   (CE_I),
    .clr_i  (cs_clr),
    .add_i  (cs_add),
    .byte_i (RX_BYTE_I),
    .sum_o  (csum)
  );
  mcver_vecmem #(.DEPTH(mcver_pkg::NUM_IRQ_C)) u_vec (
    .clk_i (CLK_I),
    .ce_i  (CE_I),
    .bus   (vif.mem)
  );

  function automatic logic is_uf(input logic [7:0] op);
    return op >= mcver_pkg::OP_UF_LO_C && op <= mcver_pkg::OP_UF_HI_C;
  endfunction
  function automatic logic [63:0] reply(input logic [7:0] st, input logic [7:0] cmd, input logic [31:0] v);
    return {mcver_pkg::HOST_ADDR_C, mcver_pkg::MOD_ADDR_C, st, cmd, v};
  endfunction

  logic [7:0] op, typ;
  logic [31:0] val;
  assign op  = s.rx_buf[55:48];
  assign typ = s.rx_buf[47:40];
  assign val = s.rx_buf[31:0];
  logic [7:0] reached_m;
  assign reached_m = 8'(REACHED_I);

  always_comb begin
    next_s = s;
    cs_clr = 1'b0;
    cs_add = 1'b0;
    vif.we = 1'b0;
    vif.waddr = typ[3:0];
    vif.wdata = val[23:0];
    vif.raddr = s.irq_num;
    case (s.st)
      S_RX: begin
        if (RX_VALID_I) begin
          if (s.rx_cnt == 4'(mcver_pkg::FRAME_LEN_C - 1)) begin
            next_s.rx_cnt = 4'h0;
            cs_clr = 1'b1;
            if (csum == RX_BYTE_I) begin
              next_s.st = S_EXEC;
            end else begin
              next_s.tx_buf = reply(mcver_pkg::ST_CHK_C, op, 32'h0);
              next_s.st = S_TX;
            end
          end else begin
            cs_add = 1'b1;
            next_s.rx_buf = {s.rx_buf[55:0], RX_BYTE_I};
            next_s.rx_cnt = s.rx_cnt + 4'h1;
          end
        end else if (s.evt_pend && s.watch != 8'h00 && (s.watch & ~reached_m) == 8'h00) begin
          next_s.evt_pend = 1'b0;
          next_s.tx_buf = reply(mcver_pkg::ST_EVT_C, mcver_pkg::OP_PREQ_C, {24'h0, s.watch});
          next_s.st = S_TX;
        end else if (s.irq_take && !s.in_irq && s.irq_glob) begin
          next_s.irq_take = 1'b0;
          next_s.st = S_WAITV;
        end
      end
      S_EXEC: begin
        next_s.st = S_TX;
        next_s.tx_buf = reply(mcver_pkg::ST_OK_C, op, 32'h0);
        if (op == mcver_pkg::OP_DEFINE_IRQ_VECTOR_C) begin
          vif.we = 1'b1;
        end else if (op == mcver_pkg::OP_RETURN_FROM_IRQ_C) begin
          if (s.in_irq) begin
            next_s.acc = s.sv_acc;
            next_s.xreg = s.sv_x;
            next_s.flags = s.sv_flags;
            next_s.pc = s.sv_pc;
            next_s.in_irq = 1'b0;
          end
        end else if (op == mcver_pkg::OP_EIRQ_C && typ == mcver_pkg::IRQ_ALL_C) begin
          next_s.irq_glob = 1'b1;
        end else if (is_uf(op)) begin
          next_s.tx_buf = reply(mcver_pkg::ST_OK_C, op, s.uf_val);
        end else if (op == mcver_pkg::OP_PREQ_C) begin
          if (s.prog_mode) begin
            next_s.tx_buf = reply(mcver_pkg::ST_BADCMD_C, op, 32'h0);
          end else begin
            next_s.mask = val[7:0];
            next_s.arm_once = (typ == 8'h00);
            next_s.arm_all = (typ == 8'h01);
            next_s.tx_buf = reply(mcver_pkg::ST_OK_C, op, {24'h0, val[7:0]});
          end
        end else if (op == mcver_pkg::OP_MVP_C && (s.arm_once || s.arm_all)) begin
          next_s.watch = s.mask;
          next_s.evt_pend = 1'b1;
          next_s.arm_once = 1'b0;
        end
      end
      S_WAITV: begin
        next_s.sv_acc = s.acc;
        next_s.sv_x = s.xreg;
        next_s.sv_flags = s.flags;
        next_s.sv_pc = s.pc;
        next_s.pc = vif.rdata;
        next_s.in_irq = 1'b1;
        next_s.st = S_RX;
      end
      S_TX: begin
        if (!s.tx_valid || TX_READY_I) begin
          if (s.tx_cnt == 4'(mcver_pkg::FRAME_LEN_C)) begin
            next_s.tx_valid = 1'b0;
            next_s.tx_cnt = 4'h0;
            next_s.st = S_RX;
          end else if (s.tx_cnt == 4'(mcver_pkg::FRAME_LEN_C - 1)) begin
            next_s.tx_valid = 1'b1;
            next_s.tx_byte = s.tx_buf[63:56] + s.tx_buf[55:48] + s.tx_buf[47:40] + s.tx_buf[39:32]
                           + s.tx_buf[31:24] + s.tx_buf[23:16] + s.tx_buf[15:8] + s.tx_buf[7:0];
            next_s.tx_cnt = s.tx_cnt + 4'h1;
          end else begin
            next_s.tx_valid = 1'b1;
            next_s.tx_byte = s.tx_buf[63:56];
            next_s.tx_buf = {s.tx_buf[55:0], s.tx_buf[63:56]};
            next_s.tx_cnt = s.tx_cnt + 4'h1;
          end
        end
      end
      default: next_s.st = S_RX;
    endcase
    // lite slave: write
    if (S_AXI_AWVALID && !s.aw_ok && !s.bvalid) begin
      next_s.aw_ok = 1'b1;
      next_s.aw_a = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && !s.w_ok && !s.bvalid) begin
      next_s.w_ok = 1'b1;
      next_s.w_d = S_AXI_WDATA;
    end
    if (s.aw_ok && s.w_ok) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mcver_pkg::RESP_OK_C;
      case (s.aw_a)
        mcver_pkg::RA_CTRL_C: begin
          next_s.prog_mode = s.w_d[0];
          if (s.w_d[1]) begin
            next_s.irq_take = 1'b1;
            next_s.irq_num = s.w_d[11:8];
          end
        end
        mcver_pkg::RA_ACC_C:  next_s.acc = s.w_d;
        mcver_pkg::RA_X_C:    next_s.xreg = s.w_d;
        mcver_pkg::RA_PC_C:   next_s.pc = s.w_d[23:0];
        mcver_pkg::RA_FLAG_C: next_s.flags = s.w_d[3:0];
        mcver_pkg::RA_UFV_C:  next_s.uf_val = s.w_d;
        default: next_s.bresp = mcver_pkg::RESP_ERR_C;
      endcase
    end
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    // lite slave: read
    if (S_AXI_ARVALID && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mcver_pkg::RESP_OK_C;
      case (S_AXI_ARADDR[7:0])
        mcver_pkg::RA_CTRL_C: next_s.rdata = {31'h0, s.prog_mode};
        mcver_pkg::RA_STAT_C: next_s.rdata = {27'h0, s.evt_pend, s.arm_all, s.arm_once, s.in_irq, s.irq_glob};
        mcver_pkg::RA_MASK_C: next_s.rdata = {16'h0, s.watch, s.mask};
        mcver_pkg::RA_ACC_C:  next_s.rdata = s.acc;
        mcver_pkg::RA_X_C:    next_s.rdata = s.xreg;
        mcver_pkg::RA_PC_C:   next_s.rdata = {8'h0, s.pc};
        mcver_pkg::RA_FLAG_C: next_s.rdata = {28'h0, s.flags};
        mcver_pkg::RA_UFV_C:  next_s.rdata = s.uf_val;
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = mcver_pkg::RESP_ERR_C;
        end
      endcase
    end else if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    // readies are registered copies of the next idle state
    next_s.aw_rdy = !next_s.aw_ok && !next_s.bvalid;
    next_s.w_rdy  = !next_s.w_ok && !next_s.bvalid;
    next_s.ar_rdy = !next_s.rvalid;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s <= '0;
      s.aw_rdy <= 1'b1;
      s.w_rdy  <= 1'b1;
      s.ar_rdy <= 1'b1;
    end else if (CE_I) begin
      s <= next_s;
    end
  end

  assign TX_VALID_O    = s.tx_valid;
  assign TX_BYTE_O     = s.tx_byte;
  assign IRQ_GLOBAL_O  = s.irq_glob;
  assign S_AXI_AWREADY = s.aw_rdy;
  assign S_AXI_WREADY  = s.w_rdy;
  assign S_AXI_BVALID  = s.bvalid;
  assign S_AXI_BRESP   = s.bresp;
  assign S_AXI_ARREADY = s.ar_rdy;
  assign S_AXI_RVALID  = s.rvalid;
  assign S_AXI_RDATA   = s.rdata;
  assign S_AXI_RRESP   = s.rresp;

  property p_irq_global;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (CE_I && s.st == S_EXEC && op == mcver_pkg::OP_EIRQ_C && typ == mcver_pkg::IRQ_ALL_C) |=> s.irq_glob;
  endproperty
  a_irq_global: assert property (p_irq_global) else $error("global enable not set");
  property p_return_from_irq;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (CE_I && s.st == S_EXEC && op == mcver_pkg::OP_RETURN_FROM_IRQ_C && s.in_irq) |=> (!s.in_irq && s.acc == $past(s.sv_acc));
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("return did not restore");
  property p_once;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (CE_I && s.st == S_EXEC && op == mcver_pkg::OP_MVP_C && s.arm_once) |=> (!s.arm_once && s.evt_pend);
  endproperty
  a_once: assert property (p_once) else $error("single arm not consumed");
  property p_direct_only;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (CE_I && s.st == S_EXEC && op == mcver_pkg::OP_PREQ_C && s.prog_mode) |=> $stable(s.mask);
  endproperty
  a_direct_only: assert property (p_direct_only) else $error("request taken in program mode");
  property p_evt_reply;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (s.st == S_TX && s.tx_cnt == 4'h0 && s.tx_buf[47:40] == mcver_pkg::ST_EVT_C)
        |-> (s.tx_buf[39:32] == mcver_pkg::OP_PREQ_C && s.tx_buf[31:0] == {24'h0, s.watch});
  endproperty
  a_evt_reply: assert property (p_evt_reply) else $error("event reply wrong command");
  property p_uf_reply;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (CE_I && s.st == S_EXEC && is_uf(op))
        |=> (s.tx_buf[47:40] == mcver_pkg::ST_OK_C && s.tx_buf[31:0] == $past(s.uf_val));
  endproperty
  a_uf_reply: assert property (p_uf_reply) else $error("user function reply wrong");
endmodule

// ==== test/mcver_host_model.sv ====
`timescale 1ns/1ps
module mcver_host_model (
  input  wire logic       clk_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_byte_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_ready_o
);
  logic slow;
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
    tx_ready_o = 1'b0;
    slow       = 1'b0;
  end
  // one nine-byte frame, bad flips the checksum lsb
  task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val, input logic bad);
    logic [71:0] f;
    logic [7:0]  s;
    f[71:8] = {mcver_pkg::MOD_ADDR_C, op, typ, 8'h00, val};
    s = 8'h00;
    for (int i = 1; i < 9; i++) s = s + f[i*8 +: 8];
    f[7:0] = s ^ {7'h00, bad};
    for (int i = 8; i >= 0; i--) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o  <= f[i*8 +: 8];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~f[7:0];
  endtask
  // slow mode drops ready every other cycle, so each byte waits one extra cycle
  task automatic recv(output logic [71:0] f);
    int n;
    n = 0;
    while (n < 9) begin
      @(posedge clk_i);
      if (tx_ready_o && tx_valid_i) begin
        f = {f[63:0], tx_byte_i};
        n++;
      end
      tx_ready_o <= (n < 9) && (!slow || !tx_ready_o);
    end
  endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk, rstn, aw_v, w_v, b_r, ar_v, r_r, tx_valid, irq_glob, awrdy, wrdy, bvalid, arrdy, rvalid, rx_valid, tx_rdy;
  logic [7:0]  tx_byte, rx_byte;
  logic [2:0]  reached;
  logic [31:0] aw_a, w_d, ar_a, rdata;
  logic [1:0]  bresp, rresp;
  int error_cnt, n_checks, cyc;
  mcver_host_model host (.clk_i(clk), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_valid_i(tx_valid),
    .tx_byte_i(tx_byte), .tx_ready_o(tx_rdy));
  mcver_top #(.NUM_MOTORS(3)) dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .RX_VALID_I(rx_valid),
    .RX_BYTE_I(rx_byte), .TX_VALID_O(tx_valid), .TX_BYTE_O(tx_byte), .TX_READY_I(tx_rdy), .REACHED_I(reached),
    .IRQ_GLOBAL_O(irq_glob), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(w_d),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_r));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // anyv: value field left open, checksum still judged
  task automatic chk_reply(input logic [71:0] f, input logic [7:0] st, input logic [7:0] op,
                           input logic [31:0] v, input logic anyv);
    logic [71:0] e;
    e[71:8] = {mcver_pkg::HOST_ADDR_C, mcver_pkg::MOD_ADDR_C, st, op, anyv ? f[39:8] : v};
    e[7:0] = 8'h00;
    for (int i = 1; i < 9; i++) e[7:0] = e[7:0] + e[i*8 +: 8];
    chk(f, e);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val, input logic [31:0] ev,
                     input logic anyv);
    logic [71:0] f;
    host.send(op, typ, val, 1'b0);
    host.recv(f);
    chk_reply(f, mcver_pkg::ST_OK_C, op, ev, anyv);
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    aw_a <= a;
    w_d  <= d;
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (aw_v && awrdy) aw_v <= 1'b0;
      if (w_v && wrdy) w_v <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    b_r <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (ar_v && arrdy) ar_v <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    r_r <= 1'b0;
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      seen = seen | tx_valid;
    end
    chk(72'(seen), 72'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw({24'h0, a}, d, r);
    chk(72'(r), 72'(mcver_pkg::RESP_OK_C));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [1:0]  r;
    logic [31:0] d;
    axr({24'h0, a}, d, r);
    chk(72'(d), 72'(e));
  endtask
  task automatic t_vector();
    cmd(mcver_pkg::OP_DEFINE_IRQ_VECTOR_C, 8'h03, 32'h32, 32'h0, 1'b1);
    cmd(mcver_pkg::OP_DEFINE_IRQ_VECTOR_C, 8'h03, 32'h50, 32'h0, 1'b1);
    cmd(mcver_pkg::OP_RETURN_FROM_IRQ_C, 8'hff, 32'h0, 32'h0, 1'b1);
  endtask
  // enter handler 3 from the register bus, clobber state, then return
  task automatic t_irq();
    wr(mcver_pkg::RA_ACC_C, 32'h11111111);
    wr(mcver_pkg::RA_X_C, 32'h22222222);
    wr(mcver_pkg::RA_FLAG_C, 32'h5);
    wr(mcver_pkg::RA_PC_C, 32'h123);
    wr(mcver_pkg::RA_CTRL_C, 32'h302);
    rd_chk(mcver_pkg::RA_PC_C, 32'h50);
    rd_chk(mcver_pkg::RA_STAT_C, 32'h3);
    wr(mcver_pkg::RA_ACC_C, 32'h99);
    wr(mcver_pkg::RA_X_C, 32'h0);
    wr(mcver_pkg::RA_FLAG_C, 32'h0);
    cmd(mcver_pkg::OP_RETURN_FROM_IRQ_C, 8'hff, 32'h0, 32'h0, 1'b1);
    rd_chk(mcver_pkg::RA_ACC_C, 32'h11111111);
    rd_chk(mcver_pkg::RA_X_C, 32'h22222222);
    rd_chk(mcver_pkg::RA_FLAG_C, 32'h5);
    rd_chk(mcver_pkg::RA_PC_C, 32'h123);
    rd_chk(mcver_pkg::RA_STAT_C, 32'h1);
  endtask
  // program mode refuses the position-reached request
  task automatic t_prog();
    logic [71:0] f;
    wr(mcver_pkg::RA_CTRL_C, 32'h1);
    host.send(mcver_pkg::OP_PREQ_C, 8'h01, 32'h3, 1'b0);
    host.recv(f);
    chk_reply(f, mcver_pkg::ST_BADCMD_C, mcver_pkg::OP_PREQ_C, 32'h0, 1'b0);
    rd_chk(mcver_pkg::RA_MASK_C, 32'h0);
    wr(mcver_pkg::RA_CTRL_C, 32'h0);
  endtask
  task automatic t_global();
    chk(72'(irq_glob), 72'h0);
    cmd(mcver_pkg::OP_EIRQ_C, 8'h03, 32'h0, 32'h0, 1'b1);
    chk(72'(irq_glob), 72'h0);
    cmd(mcver_pkg::OP_EIRQ_C, mcver_pkg::IRQ_ALL_C, 32'h0, 32'h0, 1'b1);
    chk(72'(irq_glob), 72'h1);
  endtask
  task automatic t_user();
    logic [1:0]  r;
    logic [31:0] d;
    axw({24'h0, mcver_pkg::RA_UFV_C}, 32'h0000a5c3, r);
    chk(72'(r), 72'(mcver_pkg::RESP_OK_C));
    axr({24'h0, mcver_pkg::RA_UFV_C}, d, r);
    chk(72'(d), 72'h0000a5c3);
    axr(32'h00000040, d, r);
    chk(72'(r), 72'(mcver_pkg::RESP_ERR_C));
    axw(32'h00000044, 32'h1, r);
    chk(72'(r), 72'(mcver_pkg::RESP_ERR_C));
    for (int op = 8'h40; op <= 8'h47; op++) cmd(8'(op), 8'h00, 32'h0, 32'h0000a5c3, 1'b0);
  endtask
  task automatic t_badsum();
    logic [71:0] f;
    host.send(mcver_pkg::OP_UF_LO_C, 8'h00, 32'h0, 1'b1);
    host.recv(f);
    chk(72'(f[71:48]), 72'({mcver_pkg::HOST_ADDR_C, mcver_pkg::MOD_ADDR_C, mcver_pkg::ST_CHK_C}));
  endtask
  // watch motors 0 and 2; motor 0 alone must not answer
  task automatic t_event(input logic [7:0] typ);
    logic [71:0] f;
    cmd(mcver_pkg::OP_PREQ_C, typ, 32'h5, 32'h5, 1'b0);
    for (int k = 0; k < 2; k++) begin
      reached <= 3'b000;
      cmd(mcver_pkg::OP_MVP_C, 8'h00, 32'h100, 32'h0, 1'b1);
      reached <= 3'b001;
      quiet(12);
      reached <= 3'b101;
      if (typ == 8'h01 || k == 0) begin
        host.recv(f);
        chk_reply(f, mcver_pkg::ST_EVT_C, mcver_pkg::OP_PREQ_C, 32'h5, 1'b0);
      end else begin
        quiet(30);
      end
    end
  endtask
  initial begin
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    rstn = 1'b0;
    reached = 3'b000;
    aw_v = 1'b0;
    w_v = 1'b0;
    b_r = 1'b0;
    ar_v = 1'b0;
    r_r = 1'b0;
    aw_a = 32'h0;
    w_d = 32'h0;
    ar_a = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_global();
    t_vector();
    t_irq();
    t_prog();
    t_user();
    t_badsum();
    t_event(8'h00);
    host.slow = 1'b1;
    t_event(8'h01);
    print_verdict();
  end
endmodule
